// file: rtl/ccd_readout_ctrl.sv
/*
 * Readout sequencer that drives the image sensor's clock phases, shutter
 * and charge-switch steering gates, and steers each pixel but the last two of
 * every row from the front end's digitised floating-gate sample.
 * Assumes front-end samples arrive synchronous to clk, one per pixel.
 */
module ccd_readout_ctrl
	import ccd_pkg::*;
#(
	parameter int FLUSH_PIXELS = 4096
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [11:0] fg_sample,
	output ccd_hreg_s hreg_a,
	output ccd_hreg_s hreg_b,
	output ccd_hreg_s hreg_c,
	output ccd_hreg_s hreg_d,
	output ccd_hout_s hout,
	output ccd_vert_s vert,
	output logic sample_strobe
);

	// ****************************************
	// Control registers
	// ****************************************
	ccd_state_e state;
	ccd_mode_e mode;
	logic use_shutter;
	logic halt_mult;
	logic [11:0] threshold;
	logic start_req;
	logic busy;
	logic frame_done;
	logic flushing;
	logic [12:0] flush_cnt;
	logic [11:0] row_cnt;
	logic [11:0] pix_cnt;
	logic [9:0] tcnt;
	logic [1:0] vstep;
	logic [STEER_DELAY-1:0] pipe_valid;
	logic [31:0] next_rdata;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode <= CCD_SINGLE;
			use_shutter <= 1'b0;
			halt_mult <= 1'b0;
			threshold <= THRESHOLD_RESET;
			start_req <= 1'b0;
		end else begin
			if (state != CCD_IDLE)
				start_req <= 1'b0;
			if (reg_wr && reg_addr == REG_CTRL) begin
				start_req <= reg_wdata[CTRL_START] | start_req;
				use_shutter <= reg_wdata[CTRL_SHUTTER];
				mode <= ccd_mode_e'(reg_wdata[CTRL_MODE_LO +: 2]);
				halt_mult <= reg_wdata[CTRL_HALT_MULT];
			end
			if (reg_wr && reg_addr == REG_THRESH)
				threshold <= reg_wdata[11:0];
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		unique case (reg_addr)
			REG_CTRL: next_rdata = {27'h0, halt_mult, mode, use_shutter, start_req};
			REG_THRESH: next_rdata = {20'h0, threshold};
			REG_STATUS: next_rdata = {29'h0, flushing, frame_done, busy};
			REG_ROW: next_rdata = {8'h0, pix_cnt, row_cnt};
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	logic [11:0] nh;
	logic [11:0] nv;
	logic quad_pat;
	assign quad_pat = (mode == CCD_DUAL_TB) || (mode == CCD_QUAD);
	assign nh = (mode == CCD_SINGLE || mode == CCD_DUAL_TB) ? NH_FULL : NH_HALF;
	assign nv = quad_pat ? NV_HALF : NV_FULL;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= CCD_IDLE;
			tcnt <= 10'h0;
			vstep <= 2'h0;
			row_cnt <= 12'h0;
			pix_cnt <= 12'h0;
			busy <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			tcnt <= tcnt + 10'h1;
			if (reg_rd && reg_addr == REG_STATUS)
				frame_done <= 1'b0;
			unique case (state)
				CCD_IDLE: begin
					tcnt <= 10'h0;
					vstep <= 2'h0;
					if (start_req && !flushing) begin
						busy <= 1'b1;
						row_cnt <= 12'h0;
						state <= use_shutter ? CCD_SHUT : CCD_FRAME;
					end
				end
				CCD_SHUT: if (tcnt == 10'(SHUT_CYCLES - 1)) begin
					tcnt <= 10'h0;
					state <= CCD_FRAME;
				end
				CCD_FRAME: if (tcnt == 10'(PD_XFER_CYCLES - 1)) begin
					tcnt <= 10'h0;
					vstep <= 2'h0;
					state <= CCD_LINE;
				end
				CCD_LINE: if (tcnt == 10'((vstep[0] ? TVB_CYCLES : TVA_CYCLES) - 1)) begin
					tcnt <= 10'h0;
					vstep <= vstep + 2'h1;
					if (vstep == 2'h3) begin
						pix_cnt <= 12'h0;
						state <= CCD_PIX;
					end
				end
				CCD_PIX: if (tcnt == 10'(PIXEL_CYCLES - 1)) begin
					tcnt <= 10'h0;
					pix_cnt <= pix_cnt + 12'h1;
					if (pix_cnt == nh - 12'h1) begin
						row_cnt <= row_cnt + 12'h1;
						vstep <= 2'h0;
						if (row_cnt == nv - 12'h1) begin
							state <= CCD_IDLE;
							busy <= 1'b0;
							frame_done <= 1'b1;
						end else
							state <= CCD_LINE;
					end
				end
				default: state <= CCD_IDLE;
			endcase
		end
	end

	// ****************************************
	// Multiplier restart flush
	// ****************************************
	// Own pixel tick: the sequencer counter stands still in idle
	logic [9:0] ftick;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flushing <= 1'b0;
			flush_cnt <= 13'h0;
			ftick <= 10'h0;
		end else if (halt_mult) begin
			flushing <= 1'b1;
			flush_cnt <= 13'h0;
			ftick <= 10'h0;
		end else if (flushing) begin
			ftick <= (ftick == 10'(PIXEL_CYCLES - 1)) ? 10'h0 : ftick + 10'h1;
			if (ftick == 10'(PIXEL_CYCLES - 1)) begin
				flush_cnt <= flush_cnt + 13'h1;
				if (flush_cnt == 13'(FLUSH_PIXELS - 1))
					flushing <= 1'b0;
			end
		end
	end

	// ****************************************
	// Steering from front-end samples
	// ****************************************
	logic half_phase;
	logic pix_clock;
	logic hstatic;
	logic sample_ok;
	logic to_mult;
	assign half_phase = tcnt < 10'(PIXEL_CYCLES / 2);
	assign hstatic = (state != CCD_PIX);
	assign sample_ok = (state == CCD_PIX) && (tcnt == 10'h0);

	always_ff @(posedge clk) begin
		if (!rst_n)
			pipe_valid <= '0;
		else
			pipe_valid <= {pipe_valid[STEER_DELAY-2:0], sample_ok};
	end

	// Sample aligned with the valid bit leaving the pipe
	assign to_mult = fg_sample <= threshold;
	assign pix_clock = half_phase;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hout <= '0;
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= sample_ok;
			if (hstatic || (halt_mult && !flushing)) begin
				hout <= '{first_output: 1'b1, second_output: 1'b0, last_gate: 1'b0, fg_transfer: 1'b0,
					steer_low_gain: 1'b0, steer_mult: 1'b0, mult_first_storage: 1'b1,
					mult_second_storage: 1'b0, mult_first_barrier: 1'b1,
					mult_second_barrier: 1'b0};
			end else begin
				hout.first_output <= pix_clock;
				hout.second_output <= !pix_clock;
				hout.last_gate <= !pix_clock;
				hout.fg_transfer <= !pix_clock;
				hout.mult_first_storage <= pix_clock;
				hout.mult_second_storage <= !pix_clock;
				hout.mult_first_barrier <= pix_clock;
				hout.mult_second_barrier <= !pix_clock;
				hout.steer_mult <= pipe_valid[STEER_DELAY-1] && to_mult;
				hout.steer_low_gain <= pipe_valid[STEER_DELAY-1] && !to_mult;
			end
		end
	end

	// ****************************************
	// Horizontal registers per mode
	// ****************************************
	ccd_hreg_s ph;
	ccd_hreg_s idle_h;
	assign ph = hstatic ? '{first_storage: 1'b1, second_storage: 1'b0, first_barrier: 1'b1, second_barrier: 1'b0}
		: '{first_storage: pix_clock, second_storage: !pix_clock,
			first_barrier: pix_clock, second_barrier: !pix_clock};
	assign idle_h = '{first_storage: 1'b1, second_storage: 1'b1, first_barrier: 1'b1, second_barrier: 1'b1};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreg_a <= idle_h;
			hreg_b <= idle_h;
			hreg_c <= idle_h;
			hreg_d <= idle_h;
		end else begin
			hreg_a <= ph;
			hreg_b <= ph;
			if (mode == CCD_SINGLE) begin
				// Swapped barriers run register b toward output a
				hreg_b <= '{first_storage: ph.first_storage, second_storage: ph.second_storage,
					first_barrier: ph.second_barrier, second_barrier: ph.first_barrier};
			end
			if (mode == CCD_QUAD) begin
				hreg_c <= ph;
				hreg_d <= ph;
			end else begin
				hreg_c <= idle_h;
				hreg_d <= idle_h;
			end
		end
	end

	// ****************************************
	// Vertical, shutter and clamp
	// ****************************************
	logic [3:0] vpat;
	always_comb begin
		vpat = 4'h3;
		unique case (vstep)
			2'h0: vpat = quad_pat ? 4'h9 : 4'h3;
			2'h1: vpat = 4'h6;
			2'h2: vpat = 4'hc;
			2'h3: vpat = 4'h9;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			vert <= '0;
		else begin
			vert.shutter <= (state == CCD_SHUT);
			vert.vphase <= (state == CCD_FRAME) ? 4'hf : ((state == CCD_LINE) ? vpat : 4'h3);
			vert.clamp <= (state == CCD_PIX) && (row_cnt != 12'hfff) && (pix_cnt == 12'h0) &&
				(tcnt < 10'(CLAMP_CYCLES - 1));
			vert.mult_flush_level <= flushing;
		end
	end

endmodule : ccd_readout_ctrl

// file: rtl/ccd_pkg.sv
/*
 * Package for the sensor readout timing controller: register map of the
 * controller, mode codes, pattern counts and timing constants.
 * Assumes a single 200 MHz clock domain.
 */
package ccd_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PIXEL_MIN_NS = 50;
	localparam int PIXEL_CYCLES = (PIXEL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TVA_NOM_NS = 1200;
	localparam int TVA_CYCLES = (TVA_NOM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TVB_NOM_NS = 1200;
	localparam int TVB_CYCLES = (TVB_NOM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SHUT_NOM_NS = 2500;
	localparam int SHUT_CYCLES = (SHUT_NOM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PD_XFER_NOM_NS = 3000;
	localparam int PD_XFER_CYCLES = (PD_XFER_NOM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLAMP_CYCLES = 28;
	localparam int STEER_DELAY = 28;
	localparam logic [11:0] THRESHOLD_RESET = 12'h07e;

	// ****************************************
	// Readout counts
	// ****************************************
	localparam logic [11:0] NH_FULL = 12'h90c;
	localparam logic [11:0] NH_HALF = 12'h486;
	localparam logic [11:0] NV_FULL = 12'h860;
	localparam logic [11:0] NV_HALF = 12'h430;

	// ****************************************
	// Controller register map
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_THRESH = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_ROW = 4'h3;
	localparam int CTRL_START = 0;
	localparam int CTRL_SHUTTER = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_HALT_MULT = 4;
	localparam int CTRL_FLUSH = 5;

	typedef enum logic [1:0] {
		CCD_SINGLE = 2'b00,
		CCD_DUAL_LR = 2'b01,
		CCD_DUAL_TB = 2'b10,
		CCD_QUAD = 2'b11
	} ccd_mode_e;

	typedef enum logic [2:0] {
		CCD_IDLE = 3'b000,
		CCD_SHUT = 3'b001,
		CCD_FRAME = 3'b010,
		CCD_LINE = 3'b011,
		CCD_PIX = 3'b100
	} ccd_state_e;

	// Horizontal register pins of one quadrant
	typedef struct packed {
		logic first_storage;
		logic second_storage;
		logic first_barrier;
		logic second_barrier;
	} ccd_hreg_s;

	// Output and multiplier gates shared by the sensor
	typedef struct packed {
		logic first_output;
		logic second_output;
		logic last_gate;
		logic fg_transfer;
		logic steer_low_gain;
		logic steer_mult;
		logic mult_first_storage;
		logic mult_second_storage;
		logic mult_first_barrier;
		logic mult_second_barrier;
	} ccd_hout_s;

	// Vertical and shutter pins
	typedef struct packed {
		logic [3:0] vphase;
		logic shutter;
		logic clamp;
		logic mult_flush_level;
	} ccd_vert_s;

endpackage : ccd_pkg

// file: dv/ccd_readout_assertions.sv
/*
 * Checker for the readout sequencer pins.
 * Assumes it is bound to ccd_readout_ctrl, one clock domain.
 */
module ccd_readout_assertions
	import ccd_pkg::*;
#(
	parameter int FLUSH_PIXELS = 4096
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [11:0] fg_sample,
	input wire ccd_hreg_s hreg_a,
	input wire ccd_hreg_s hreg_b,
	input wire ccd_hreg_s hreg_c,
	input wire ccd_hreg_s hreg_d,
	input wire ccd_hout_s hout,
	input wire ccd_vert_s vert,
	input wire logic sample_strobe
);
	// ****************************************
	// Helpers
	// ****************************************
	ccd_mode_e mode_q;
	ccd_mode_e mode_w;
	int shut_cnt;
	int clamp_run;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_w <= CCD_SINGLE;
			mode_q <= CCD_SINGLE;
		end else begin
			mode_q <= mode_w;
			if (reg_wr && reg_addr == REG_CTRL)
				mode_w <= ccd_mode_e'(reg_wdata[CTRL_MODE_LO +: 2]);
		end
	end
	always_ff @(posedge clk) begin
		shut_cnt <= (!rst_n || !vert.shutter) ? 0 : shut_cnt + 1;
		clamp_run <= (!rst_n || !vert.clamp) ? 0 : clamp_run + 1;
	end
	// ****************************************
	// Properties
	// ****************************************
	a_mult_quiet: assert property (vert.shutter && $past(vert.shutter) |-> $stable(hout[3:0]))
		else $error("multiplier phase moved under shutter");
	a_static_levels: assert property (vert.shutter |-> hout == 10'h20a)
		else $error("gates not static under shutter");
	a_shutter_width: assert property ($fell(vert.shutter) |-> shut_cnt >= 400 && shut_cnt <= 2000)
		else $error("shutter width out of range");
	a_clamp_window: assert property (vert.clamp |-> clamp_run < 28)
		else $error("clamp too long");
	a_pixel_period: assert property (sample_strobe |=> !sample_strobe [*8] ##1 !sample_strobe)
		else $error("pixel period short");
	a_steer_onehot: assert property (!(hout.steer_low_gain && hout.steer_mult))
		else $error("both steering gates high");
	a_unused_high: assert property (mode_q inside {CCD_SINGLE, CCD_DUAL_LR} |-> hreg_c == 4'hf && hreg_d == 4'hf)
		else $error("unused register not high");
	a_single_cross: assert property (mode_q == CCD_SINGLE |-> hreg_a.first_barrier == hreg_b.second_barrier
		&& hreg_a.first_storage == hreg_b.first_storage && hreg_a.first_barrier == hreg_a.first_storage)
		else $error("single mode wiring wrong");
	a_pair_ab: assert property (mode_q inside {CCD_DUAL_LR, CCD_QUAD} |-> hreg_a == hreg_b)
		else $error("a and b differ");
	a_pair_cd: assert property (mode_q == CCD_QUAD |-> hreg_c == hreg_d)
		else $error("c and d differ");
	c_shutter: cover property ($rose(vert.shutter));
	c_mult: cover property ($rose(hout.steer_mult));
	c_low_gain: cover property ($rose(hout.steer_low_gain));
endmodule : ccd_readout_assertions

bind ccd_readout_ctrl ccd_readout_assertions #(.FLUSH_PIXELS(FLUSH_PIXELS)) u_chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.fg_sample(fg_sample), .hreg_a(hreg_a), .hreg_b(hreg_b), .hreg_c(hreg_c), .hreg_d(hreg_d),
	.hout(hout), .vert(vert), .sample_strobe(sample_strobe));

// file: dv/ccd_sensor_model.sv
/*
 * Sensor and front end model: each pixel places a packet under the
 * floating gate; its reading leaves the converter pipe later.
 * Assumes the bench sets the packet size on charge.
 */
module ccd_sensor_model
	import ccd_pkg::*;
(
	input wire logic clk,
	input wire logic [11:0] charge,
	input wire logic sample_strobe,
	output logic [11:0] fg_sample
);
	// ****************************************
	// Floating gate and converter pipe
	// ****************************************
	logic [11:0] packet = 12'h000;
	// Strobe and packet stages make up the rest of the latency
	logic [(STEER_DELAY-2)*12-1:0] pipe = '0;
	always_ff @(posedge clk) begin
		if (sample_strobe) begin
			packet <= charge;
		end
	end
	always_ff @(posedge clk) begin
		pipe <= {pipe[(STEER_DELAY-2)*12-13:0], packet};
	end
	assign fg_sample = pipe[(STEER_DELAY-2)*12-1 -: 12];
endmodule : ccd_sensor_model

// file: dv/ccd_readout_timing_control_bench.sv
/*
 * Bench: register access, shutter width, pixels per row and routing.
 * Assumes the checker is bound and the sensor model drives fg_sample.
 */
module ccd_readout_timing_control_bench
	import ccd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals and tasks
	// ****************************************
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sample_strobe, shut_seen = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
	logic [11:0] fg_sample, charge = 12'h07e;
	ccd_hreg_s hreg_a, hreg_b, hreg_c, hreg_d;
	ccd_hout_s hout;
	ccd_vert_s vert;
	int errors = 0, n_compared = 0, cnt, pix, n_lg, n_em;
	always #2.5 clk = ~clk;
	always @(negedge clk) if (vert.shutter === 1'b1) shut_seen = 1;
	ccd_readout_ctrl #(.FLUSH_PIXELS(4)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fg_sample(fg_sample),
		.hreg_a(hreg_a), .hreg_b(hreg_b), .hreg_c(hreg_c), .hreg_d(hreg_d), .hout(hout), .vert(vert),
		.sample_strobe(sample_strobe));
	ccd_sensor_model u_sensor (.clk(clk), .charge(charge), .sample_strobe(sample_strobe), .fg_sample(fg_sample));
	task test_done;
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	task check32(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check32
	task bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask : bus_wr
	task bus_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		d = reg_rdata;
	endtask : bus_rd
	task wait_lvl(input bit shut, input logic lvl);
		for (int i = 0; i < 40000; i++) begin
			@(negedge clk);
			if ((shut ? vert.shutter : vert.clamp) === lvl) return;
		end
		errors++;
		$display("Error %0t: wait ran out", $time);
		test_done();
	endtask : wait_lvl
	task count_row;
		logic cq, plg, pem;
		wait_lvl(0, 1);
		pix = sample_strobe;
		n_lg = 0;
		n_em = 0;
		cq = 1;
		plg = hout.steer_low_gain;
		pem = hout.steer_mult;
		for (int i = 0; i < 30000; i++) begin
			@(negedge clk);
			if (vert.clamp === 1'b1 && !cq) return;
			cq = vert.clamp;
			pix += sample_strobe;
			n_lg += int'(hout.steer_low_gain === 1'b1 && plg !== 1'b1);
			n_em += int'(hout.steer_mult === 1'b1 && pem !== 1'b1);
			plg = hout.steer_low_gain;
			pem = hout.steer_mult;
		end
		errors++;
		$display("Error %0t: row end not seen", $time);
		test_done();
	endtask : count_row
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		bus_rd(REG_THRESH, rd);
		check32(rd, {20'h0, THRESHOLD_RESET}, "threshold reset");
		bus_rd(REG_STATUS, rd);
		check32(rd, 32'h0, "status reset");
		bus_rd(4'h9, rd);
		check32(rd, 32'h0, "unmapped read");
		bus_wr(REG_THRESH, 32'h7f);
		bus_rd(REG_THRESH, rd);
		check32(rd, 32'h7f, "threshold write");
		bus_wr(REG_THRESH, 32'h7e);
		bus_wr(REG_CTRL, 32'h3);
		wait_lvl(1, 1);
		for (cnt = 0; cnt < 5000 && vert.shutter === 1'b1; cnt++) @(negedge clk);
		check32(32'(cnt), 32'(SHUT_CYCLES), "shutter width");
		for (cnt = 0; cnt < 5000 && vert.vphase === 4'hf; cnt++) @(negedge clk);
		check32(32'(cnt), 32'(PD_XFER_CYCLES), "photodiode transfer");
		bus_rd(REG_STATUS, rd);
		check32(rd & 32'h1, 32'h1, "busy");
		for (cnt = 0; cnt < 5000 && vert.vphase !== 4'h6; cnt++) @(negedge clk);
		for (cnt = 0; cnt < 5000 && vert.vphase === 4'h6; cnt++) @(negedge clk);
		check32(32'(cnt), 32'(TVB_CYCLES), "transfer interval b");
		for (cnt = 0; cnt < 5000 && vert.vphase === 4'hc; cnt++) @(negedge clk);
		check32(32'(cnt), 32'(TVA_CYCLES), "transfer interval a");
		count_row();
		check32(32'(pix), 32'(NH_FULL), "single pixels");
		check32(32'(n_lg), 32'h0, "low gain at threshold");
		check32(32'(n_em > 0), 32'h1, "multiplier used");
		@(posedge clk);
		rst_n <= 0;
		charge <= 12'h07f;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		shut_seen = 0;
		bus_wr(REG_CTRL, 32'hd);
		count_row();
		check32(32'(pix), 32'(NH_HALF), "quad pixels");
		check32(32'(n_em), 32'h0, "multiplier above threshold");
		check32(32'(n_lg > 0), 32'h1, "low gain used");
		check32({31'h0, shut_seen}, 32'h0, "shutter skipped");
		bus_wr(REG_CTRL, 32'h1c);
		bus_rd(REG_STATUS, rd);
		check32(rd & 32'h4, 32'h4, "flush pending");
		bus_wr(REG_CTRL, 32'hc);
		repeat (60) @(posedge clk);
		bus_rd(REG_STATUS, rd);
		check32(rd & 32'h4, 32'h0, "flush finished");
		test_done();
	end
endmodule : ccd_readout_timing_control_bench
